// File: shared/fsc_pkg.sv
// Constants and register map for the flash security and clock scaler block
package fsc_pkg;
    // =====================================================
    // Register byte offsets on APB
    localparam logic [11:0] OFS_SCALER = 12'h000;
    localparam logic [11:0] OFS_OPTION = 12'h004;
    localparam logic [11:0] OFS_CONFIG = 12'h008;
    localparam logic [11:0] OFS_PROT   = 12'h00c;
    localparam logic [11:0] OFS_SPARE  = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    // =====================================================
    // Field positions
    localparam int SCL_LOADED_BIT  = 7;
    localparam int SCL_PRESC_BIT   = 6;
    localparam int OPT_BACKDOOR_KEY_ENABLE_BIT   = 7;
    localparam int CFG_KEY_ACCESS_ENABLE_BIT  = 5;
    localparam logic [7:0] OPT_READ_MASK = 8'hc3;
    localparam logic [7:0] CFG_READ_MASK = 8'he0;
    // =====================================================
    // Security codes and key window
    localparam logic [1:0]  SEC_OPEN      = 2'h2;
    localparam logic [15:0] KEY_BASE_ADDR = 16'hffb0;
    localparam int          KEY_BYTES     = 8;
    localparam logic [3:0]  KEY_FULL      = 4'h8;
    localparam logic [2:0]  PRESC_LAST    = 3'h7;
    // =====================================================
    // Reset values
    localparam logic [7:0] SCALER_RST = 8'h00;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // Bus clock, used only to document the scaler ratio
    localparam int CLK_HZ = 20_000_000;
endpackage

// File: verif/fsc_apb_host.sv
// APB master model standing in for the core and the background debug controller
`timescale 1ns/1ps
module fsc_apb_host (
    input  wire logic        pclk,       // Bus clock
    input  wire logic        presetn,    // Async reset, low
    input  wire logic        req,        // Start pulse from bench
    input  wire logic        req_wr,     // Write request
    input  wire logic [11:0] req_addr,   // Byte address
    input  wire logic [31:0] req_data,   // Write data
    input  wire logic        req_dbg,    // Issued by debug controller
    output logic             done,       // Transfer finished pulse
    output logic [31:0]      rdata,      // Captured read data
    output logic             err,        // Captured pslverr
    output logic             psel,       // APB select
    output logic             penable,    // APB enable
    output logic             pwrite,     // APB direction
    output logic             dbg_master, // Debug owns transfer
    output logic [11:0]      paddr,      // APB address
    output logic [31:0]      pwdata,     // APB write data
    input  wire logic        pready,     // APB ready
    input  wire logic [31:0] prdata,     // APB read data
    input  wire logic        pslverr     // APB error
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {psel, penable, pwrite, dbg_master, done, err} <= '0;
            {paddr, pwdata, rdata} <= '0;
        end else begin
            done <= 1'b0;
            if (req && !psel) begin
                {psel, pwrite, paddr, pwdata, dbg_master} <= {1'b1, req_wr, req_addr, req_data, req_dbg};
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (penable && pready) begin
                {psel, penable, done, rdata, err} <= {2'b00, 1'b1, prdata, pslverr};
                // Released lines change so nothing relies on a stale value
                {paddr, pwdata} <= {~paddr, ~pwdata};
            end
        end
    end
endmodule // fsc_apb_host

// File: verif/fsc_top_tb.sv
// Self-checking testbench for the flash security and clock scaler block
`timescale 1ns/1ps
module fsc_top_tb;
    import fsc_pkg::*;
    typedef struct {logic wr; logic tsec; logic ssec; logic sdbg; logic ewr; logic [7:0] erd;} fsc_row_s;
    logic pclk = 0, presetn = 0, req = 0, req_wr = 0, req_dbg = 0, done, err;
    logic [11:0] req_addr = '0;
    logic [31:0] req_data = '0, rdata;
    logic psel, penable, pwrite, dbg_master, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] nv_opt = 8'h83, rd_data;
    logic acc_valid = 0, acc_write = 0, tsec = 0, is_flash = 0, ssec = 0, sram = 0, sdbg = 0;
    logic [15:0] acc_addr = '0;
    logic [7:0] acc_wdata = '0;
    logic blank_done = 0, blank_pass = 0, pin_low = 0;
    logic mem_wr_en, cmd_start, acc_err_set, rd_valid, pe_enable, fclk_tick, secure, dbg_en, bgnd_en;
    logic [63:0] key = 64'h8877_6655_4433_2211;
    int errors = 0, checks = 0, n;
    fsc_row_s rows[7] = '{
        '{0, 1, 1, 0, 0, 8'h5a},  // Secure code reads secure memory
        '{0, 1, 0, 0, 0, 8'h00},  // Unsecured code read blocked
        '{0, 1, 1, 1, 0, 8'h00},  // Debug read blocked
        '{0, 0, 0, 0, 0, 8'h5a},  // Unsecured resource stays open
        '{1, 1, 1, 0, 1, 8'h00},  // Secure code write passes
        '{1, 1, 0, 0, 0, 8'h00},  // Unsecured code write dropped
        '{1, 1, 1, 1, 0, 8'h00}}; // Debug write dropped

    fsc_apb_host host (.pclk(pclk), .presetn(presetn), .req(req), .req_wr(req_wr), .req_addr(req_addr),
        .req_data(req_data), .req_dbg(req_dbg), .done(done), .rdata(rdata), .err(err), .psel(psel),
        .penable(penable), .pwrite(pwrite), .dbg_master(dbg_master), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    fsc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .dbg_master(dbg_master), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .nv_option_byte(nv_opt), .nv_prot_byte(8'hde), .nv_spare_byte(8'h5b),
        .backdoor_key_store(key), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_target_sec(tsec), .acc_is_flash(is_flash), .src_secure(ssec),
        .src_ram(sram), .src_debug(sdbg), .mem_rdata_in(8'h5a), .blank_done(blank_done),
        .blank_pass(blank_pass), .dbg_module_req(1'b1), .bgnd_req(1'b1), .bgnd_pin_low(pin_low),
        .mem_wr_en(mem_wr_en), .cmd_start(cmd_start), .acc_err_set(acc_err_set), .rd_valid(rd_valid),
        .rd_data(rd_data), .pe_enable(pe_enable), .fclk_tick(fclk_tick), .secure(secure),
        .dbg_module_en(dbg_en), .bgnd_en(bgnd_en));

    initial begin
        forever #25 pclk = ~pclk;
    end

    // ====================================================
    // Compare, bus and access tasks
    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %b got %b", name, exp, got);
        end
    endtask

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask

    // Waits for the answer however long it takes; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic dbg);
        @(posedge pclk);
        {req, req_wr, req_addr, req_data, req_dbg} <= {1'b1, w, a, d, dbg};
        @(posedge pclk);
        req <= 1'b0;
        do begin
            @(posedge pclk);
            #1;
        end while (done !== 1'b1);
        chk_bit("pready_one_cycle", 1'b0, pready);
    endtask

    // Memory access taken at the edge where the strobe is high; results show one cycle later
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic ts, input logic fl, input logic ss, input logic sr, input logic sd);
        @(posedge pclk);
        {acc_valid, acc_write, acc_addr, acc_wdata, tsec, is_flash, ssec, sram, sdbg} <= {1'b1, w, a, d, ts, fl, ss, sr, sd};
        @(posedge pclk);
        acc_valid <= 1'b0;
        #1;
    endtask

    task automatic rst(input logic [7:0] opt, input logic pin);
        @(posedge pclk);
        {presetn, nv_opt, pin_low} <= {1'b0, opt, pin};
        repeat (6) @(posedge pclk);
        #1 chk_bit("secure_in_reset", 1'b1, secure);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
    endtask

    // Key bytes go in ascending order with an idle cycle between them
    task automatic key_entry(input logic [7:0] spoil);
        apb(1, OFS_CONFIG, 32'h20, 0);
        for (int i = 0; i < KEY_BYTES; i++) begin
            acc(1, KEY_BASE_ADDR + 16'(i), key[8*i +: 8] ^ (i == 0 ? spoil : 8'h00), 1, 1, 1, 1, 0);
            chk_bit("cmd_start_key", 1'b0, cmd_start);
        end
        acc(0, 16'h8000, 8'h00, 1, 1, 1, 1, 0);
        chk_word("rd_key_access", 32'h0, {24'h0, rd_data});
        apb(1, OFS_CONFIG, 32'h00, 0);
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #2_000_000;
        errors++;
        $display("[ERR] watchdog exp finish got timeout");
        wrap_up();
    end

    // ====================================================
    // Main sequence
    initial begin
        rst(8'h83, 1'b0);
        apb(0, OFS_SCALER, 0, 0);
        chk_word("scaler_rst", 32'h00, rdata);
        apb(0, OFS_OPTION, 0, 0);
        chk_word("option", 32'h83, rdata);
        apb(0, OFS_PROT, 0, 0);
        chk_word("prot", 32'hde, rdata);
        apb(0, OFS_SPARE, 0, 0);
        chk_word("spare", 32'h5b, rdata);
        apb(0, 12'h018, 0, 0);
        chk_bit("unmapped_err", 1'b1, err);
        chk_bit("secure", 1'b1, secure);
        chk_bit("dbg_module_en", 1'b0, dbg_en);
        chk_bit("bgnd_en", 1'b0, bgnd_en);
        $display("test reset done");
        foreach (rows[i]) begin
            acc(rows[i].wr, 16'h0100, 8'h3c, rows[i].tsec, 0, rows[i].ssec, rows[i].ssec, rows[i].sdbg);
            chk_bit("mem_wr_en", rows[i].ewr, mem_wr_en);
            chk_bit("rd_valid", !rows[i].wr, rd_valid);
            if (!rows[i].wr) chk_word("rd_data", {24'h0, rows[i].erd}, {24'h0, rd_data});
        end
        $display("test access table done");
        acc(1, 16'h8000, 8'h11, 1, 1, 1, 0, 0);
        chk_bit("acc_err_set", 1'b1, acc_err_set);
        chk_bit("cmd_start_early", 1'b0, cmd_start);
        chk_bit("pe_enable_early", 1'b0, pe_enable);
        // Prescale on, ratio 12: 20 MHz / 104 sits inside the flash clock window
        apb(1, OFS_SCALER, 32'h4c, 0);
        apb(1, OFS_SCALER, 32'h01, 0);
        apb(0, OFS_SCALER, 0, 0);
        chk_word("scaler", 32'hcc, rdata);
        chk_bit("pe_enable", 1'b1, pe_enable);
        acc(1, 16'h8000, 8'h11, 1, 1, 1, 0, 0);
        chk_bit("cmd_start", 1'b1, cmd_start);
        n = 0;
        while (fclk_tick !== 1'b1 && n < 300) begin
            @(posedge pclk);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge pclk);
            #1 n++;
        end while (fclk_tick !== 1'b1 && n < 300);
        chk_word("tick_period", 32'(8 * (12 + 1)), 32'(n));
        $display("test scaler done");
        apb(1, OFS_PROT, 32'h0f, 0);
        apb(0, OFS_PROT, 0, 0);
        chk_word("prot_app", 32'hde, rdata);
        apb(1, OFS_PROT, 32'h0f, 1);
        apb(0, OFS_PROT, 0, 1);
        chk_word("prot_dbg", 32'h0f, rdata);
        $display("test protection done");
        key_entry(8'hff);
        chk_bit("secure_bad_key", 1'b1, secure);
        key_entry(8'h00);
        chk_bit("secure_key", 1'b0, secure);
        chk_bit("dbg_module_open", 1'b1, dbg_en);
        apb(0, OFS_OPTION, 0, 0);
        chk_word("option_open", 32'h82, rdata);
        apb(0, OFS_STATUS, 0, 0);
        chk_word("key_count", 32'h8, rdata);
        $display("test key done");
        rst(8'h83, 1'b1);
        chk_bit("secure_again", 1'b1, secure);
        chk_bit("bgnd_strap", 1'b1, bgnd_en);
        @(posedge pclk);
        {blank_done, blank_pass} <= 2'b10;
        @(posedge pclk);
        {blank_done, blank_pass} <= 2'b11;
        @(posedge pclk);
        blank_done <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 chk_bit("secure_blank", 1'b0, secure);
        $display("test blank done");
        rst(8'h03, 1'b0);
        key_entry(8'h00);
        chk_bit("secure_backdoor_key_enable_off", 1'b1, secure);
        $display("test key disabled done");
        wrap_up();
    end
endmodule // fsc_top_tb

// File: verilog/fsc_top.sv
// Flash security gate, option shadows and flash clock scaler with APB slave
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Block unsecured or debug secure accesses
// - Secure-fetched code gets full access
// - Only code 1:0 means unsecured
// - Reset copies option byte to shadow
// - No debug module while secure
// - Secure background entry only via pin
// - Key enable 0 disables key compare
// - Key access captures key writes
// - Key match on clear unsecures device
// - Key writes accepted only from RAM
// - Protection writable only by debug
// - Passing blank check unsecures device
// - Reset loads three config shadows
// - Scaler bits take first write only
// - Loaded flag gates program and erase
// - Prescale picks bus or bus/8
// - Flash clock is input over ratio+1
// - Timing pulses are whole flash clocks; this block only makes fclk_tick, one bus cycle wide per flash clock
// - Flash reads under key access return zero
// - Early flash write raises access error
// - Field reads 10 after unlock
module fsc_top
    import fsc_pkg::*;
(
    input  wire logic        pclk,          // Bus clock
    input  wire logic        presetn,       // Async reset, low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [11:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    input  wire logic        dbg_master,    // APB transfer issued by debug
    output logic             pready,        // APB ready
    output logic [31:0]      prdata,        // APB read data
    output logic             pslverr,       // APB error, unmapped
    input  wire logic [7:0]  nv_option_byte,// Nonvolatile option byte
    input  wire logic [7:0]  nv_prot_byte,  // Nonvolatile protection byte
    input  wire logic [7:0]  nv_spare_byte, // Third nonvolatile config byte
    input  wire logic [63:0] backdoor_key_store, // Byte i at [8i+7:8i]
    input  wire logic        acc_valid,     // Memory access strobe
    input  wire logic        acc_write,     // Access is a write
    input  wire logic [15:0] acc_addr,      // Access address
    input  wire logic [7:0]  acc_wdata,     // Write byte
    input  wire logic        acc_target_sec,// Target is secured flash or RAM
    input  wire logic        acc_is_flash,  // Target is flash array
    input  wire logic        src_secure,    // Code fetched from secure memory
    input  wire logic        src_ram,       // Code executing in RAM
    input  wire logic        src_debug,     // Access from debug controller
    input  wire logic [7:0]  mem_rdata_in,  // Raw array read data
    input  wire logic        blank_done,    // Blank check finished pulse
    input  wire logic        blank_pass,    // Blank check found all erased
    input  wire logic        dbg_module_req,// Request to enable debug module
    input  wire logic        bgnd_req,      // Other request for background mode
    input  wire logic        bgnd_pin_low,  // Background mode pin held low
    output logic             mem_wr_en,     // Write passed to memory, pulse
    output logic             cmd_start,     // Flash command write step, pulse
    output logic             acc_err_set,   // Sets access error flag, pulse
    output logic             rd_valid,      // Read data valid, pulse
    output logic [7:0]       rd_data,       // Gated read data
    output logic             pe_enable,     // Program and erase allowed
    output logic             fclk_tick,     // One bus cycle per flash clock
    output logic             secure,        // Security engaged
    output logic             dbg_module_en, // Debug module enabled
    output logic             bgnd_en        // Active background mode allowed
);
    // =====================================================
    // State
    typedef struct packed {
        logic [7:0]  opt;
        logic [7:0]  prot;
        logic [7:0]  spare;
        logic        loaded;
        logic        presc;
        logic [5:0]  ratio;
        logic        key_acc;
        logic [63:0] key_buf;
        logic [3:0]  key_cnt;
        logic        key_bad;
        logic [2:0]  pre_cnt;
        logic [5:0]  div_cnt;
        logic        tick;
        logic        pin_caught;
        logic        load_done;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        mem_wr_en;
        logic        cmd_start;
        logic        acc_err;
        logic        rd_valid;
        logic [7:0]  rd_data;
        logic        secure;
        logic        dbg_en;
        logic        bgnd_en;
    } fsc_state_s;

    fsc_state_s st_r;
    fsc_state_s st_nxt;

    function automatic logic fsc_is_secure(input logic [1:0] code);
        return code != SEC_OPEN;
    endfunction

    function automatic logic fsc_is_key_addr(input logic [15:0] a);
        return a[15:3] == KEY_BASE_ADDR[15:3];
    endfunction

    logic apb_fire;
    logic apb_wr;
    logic apb_rd;
    logic sec_now;
    logic blocked;
    logic key_wr;
    logic key_match;

    always_comb begin
        apb_fire  = psel && penable && st_r.pready;
        apb_wr    = apb_fire && pwrite;
        apb_rd    = apb_fire && !pwrite;
        sec_now   = fsc_is_secure(st_r.opt[1:0]);
        blocked   = sec_now && acc_target_sec && (!src_secure || src_debug);
        key_wr    = acc_valid && acc_write && st_r.key_acc && fsc_is_key_addr(acc_addr)
                    && src_ram && !src_debug;
        // Compare only with key enable set
        key_match = st_r.opt[OPT_BACKDOOR_KEY_ENABLE_BIT] && st_r.key_cnt == KEY_FULL && !st_r.key_bad
                    && st_r.key_buf == backdoor_key_store;
    end

    always_comb begin
        st_nxt           = st_r;
        st_nxt.mem_wr_en = 1'b0;
        st_nxt.cmd_start = 1'b0;
        st_nxt.acc_err   = 1'b0;
        st_nxt.rd_valid  = 1'b0;
        st_nxt.tick      = 1'b0;
        // =====================================================
        // Shadow load after reset release
        if (!st_r.load_done) begin
            st_nxt.load_done  = 1'b1;
            st_nxt.opt        = nv_option_byte;
            st_nxt.prot       = nv_prot_byte;
            st_nxt.spare      = nv_spare_byte;
            st_nxt.pin_caught = bgnd_pin_low;
        end
        // =====================================================
        // APB slave: one wait state, data registered
        st_nxt.pready  = psel && penable && !st_r.pready;
        st_nxt.pslverr = 1'b0;
        if (psel && penable && !st_r.pready) begin
            st_nxt.prdata = WORD_ZERO;
            unique case (paddr)
                OFS_SCALER: st_nxt.prdata[7:0] = {st_r.loaded, st_r.presc, st_r.ratio};
                OFS_OPTION: st_nxt.prdata[7:0] = st_r.opt & OPT_READ_MASK;
                OFS_CONFIG: st_nxt.prdata[CFG_KEY_ACCESS_ENABLE_BIT] = st_r.key_acc;
                OFS_PROT:   st_nxt.prdata[7:0] = st_r.prot;
                OFS_SPARE:  st_nxt.prdata[7:0] = st_r.spare;
                OFS_STATUS: st_nxt.prdata[3:0] = st_r.key_cnt;
                default:    st_nxt.pslverr = 1'b1;
            endcase
        end
        if (apb_wr) begin
            unique case (paddr)
                OFS_SCALER: begin
                    // First write only, flag set regardless
                    if (!st_r.loaded) begin
                        st_nxt.loaded = 1'b1;
                        st_nxt.presc  = pwdata[SCL_PRESC_BIT];
                        st_nxt.ratio  = pwdata[5:0];
                    end
                end
                OFS_CONFIG: begin
                    st_nxt.key_acc = pwdata[CFG_KEY_ACCESS_ENABLE_BIT];
                    if (!st_r.key_acc && pwdata[CFG_KEY_ACCESS_ENABLE_BIT]) begin
                        st_nxt.key_cnt = 4'h0;
                        st_nxt.key_bad = 1'b0;
                    end
                    // Unlock on clear only when matched
                    if (st_r.key_acc && !pwdata[CFG_KEY_ACCESS_ENABLE_BIT] && key_match) begin
                        st_nxt.opt[1:0] = SEC_OPEN;
                    end
                end
                OFS_PROT: begin
                    if (dbg_master) begin
                        st_nxt.prot = pwdata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // =====================================================
        // Memory access gate
        if (acc_valid && acc_write) begin
            if (key_wr) begin
                // Out-of-order or extra bytes spoil the whole entry
                if (acc_addr[2:0] != st_r.key_cnt[2:0] || st_r.key_cnt == KEY_FULL) begin
                    st_nxt.key_bad = 1'b1;
                end else begin
                    st_nxt.key_buf[{acc_addr[2:0], 3'h0} +: 8] = acc_wdata;
                    st_nxt.key_cnt = st_r.key_cnt + 4'h1;
                end
            end else if (st_r.key_acc && fsc_is_key_addr(acc_addr)) begin
                // Key window writes from elsewhere do nothing
                st_nxt.key_bad = st_r.key_bad;
            end else if (!blocked) begin
                if (acc_is_flash) begin
                    if (!st_r.loaded) begin
                        st_nxt.acc_err = 1'b1;
                    end else begin
                        st_nxt.cmd_start = 1'b1;
                    end
                end else begin
                    st_nxt.mem_wr_en = 1'b1;
                end
            end
        end
        if (acc_valid && !acc_write) begin
            st_nxt.rd_valid = 1'b1;
            // Zero for blocked reads or flash reads under key access
            if (blocked || (st_r.key_acc && acc_is_flash)) begin
                st_nxt.rd_data = BYTE_RST;
            end else begin
                st_nxt.rd_data = mem_rdata_in;
            end
        end
        if (blank_done && blank_pass) begin
            st_nxt.opt[1:0] = SEC_OPEN;
        end
        // =====================================================
        // Flash clock scaler
        if (st_r.loaded) begin
            if (!st_r.presc || st_r.pre_cnt == PRESC_LAST) begin
                st_nxt.pre_cnt = 3'h0;
                if (st_r.div_cnt == st_r.ratio) begin
                    st_nxt.div_cnt = 6'h00;
                    st_nxt.tick    = 1'b1;
                end else begin
                    st_nxt.div_cnt = st_r.div_cnt + 6'h01;
                end
            end else begin
                st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
            end
        end
        // =====================================================
        // Debug and background gating
        st_nxt.secure  = fsc_is_secure(st_nxt.opt[1:0]);
        st_nxt.dbg_en  = dbg_module_req && !st_nxt.secure;
        st_nxt.bgnd_en = st_nxt.secure ? st_nxt.pin_caught : (bgnd_req || st_nxt.pin_caught);
    end

    // Reset clears the unlock; reload follows release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= '0;
            st_r.opt    <= BYTE_RST;
            st_r.secure <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready        = st_r.pready;
    assign prdata        = st_r.prdata;
    assign pslverr       = st_r.pslverr;
    assign mem_wr_en     = st_r.mem_wr_en;
    assign cmd_start     = st_r.cmd_start;
    assign acc_err_set   = st_r.acc_err;
    assign rd_valid      = st_r.rd_valid;
    assign rd_data       = st_r.rd_data;
    assign pe_enable     = st_r.loaded;
    assign fclk_tick     = st_r.tick;
    assign secure        = st_r.secure;
    assign dbg_module_en = st_r.dbg_en;
    assign bgnd_en       = st_r.bgnd_en;

    // =====================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_blocked_rd;
        acc_valid && !acc_write && blocked;
    endsequence

    sequence s_zero_out;
        rd_valid && rd_data == BYTE_RST;
    endsequence

    a_blocked_read_zero: assert property (s_blocked_rd |=> s_zero_out)
        else $error("blocked read not zero");
    a_blocked_write_drop: assert property (acc_valid && acc_write && blocked |=> !mem_wr_en && !cmd_start)
        else $error("blocked write passed");
    a_secure_fetch_free: assert property (acc_valid && acc_write && src_secure && !src_debug
        && !acc_is_flash && !st_r.key_acc |=> mem_wr_en)
        else $error("secure code write refused");
    a_secure_code_map: assert property (st_r.load_done && $stable(st_r.opt) |=> secure == (st_r.opt[1:0] != SEC_OPEN))
        else $error("security decode wrong");
    a_shadow_load: assert property ($rose(presetn) |-> ##0 !st_r.load_done ##1 st_r.opt == $past(nv_option_byte)
        && st_r.prot == $past(nv_prot_byte))
        else $error("shadow not loaded");
    a_debug_blocked: assert property (secure |-> !dbg_module_en)
        else $error("debug enabled while secure");
    a_bgnd_pin_only: assert property (secure && !st_r.pin_caught |-> !bgnd_en)
        else $error("background entered while secure");
    a_backdoor_key_enable_off: assert property (!st_r.opt[OPT_BACKDOOR_KEY_ENABLE_BIT] && !blank_done && $stable(nv_option_byte) && secure
        && st_r.load_done |=> secure)
        else $error("unlock without key enable");
    a_key_no_cmd: assert property (key_wr |=> !cmd_start && !acc_err_set)
        else $error("key write started command");
    a_key_debug_refused: assert property (acc_valid && src_debug && st_r.key_acc |=> $stable(st_r.key_cnt))
        else $error("debug entered key byte");
    a_key_unlock: assert property (apb_wr && paddr == OFS_CONFIG && st_r.key_acc && !pwdata[CFG_KEY_ACCESS_ENABLE_BIT]
        && key_match |=> st_r.opt[1:0] == SEC_OPEN ##1 !secure)
        else $error("key match did not unlock");
    a_key_mismatch: assert property (apb_wr && paddr == OFS_CONFIG && !key_match && !blank_done
        && st_r.load_done |=> $stable(st_r.opt))
        else $error("mismatch changed security");
    a_prot_app_write: assert property (apb_wr && paddr == OFS_PROT && !dbg_master |=> $stable(st_r.prot))
        else $error("application wrote protection");
    a_blank_unlock: assert property (blank_done && blank_pass && st_r.load_done |=> ##1 !secure)
        else $error("blank check did not unlock");
    a_scaler_once: assert property (st_r.loaded |=> $stable({st_r.presc, st_r.ratio}))
        else $error("scaler rewritten");
    a_loaded_flag: assert property (apb_wr && paddr == OFS_SCALER |=> pe_enable)
        else $error("loaded flag not set");
    a_tick_gap: assert property (fclk_tick && st_r.presc && st_r.ratio == 6'h0c
        |=> !fclk_tick ##103 fclk_tick)
        else $error("flash clock ratio wrong");
    a_early_flash_err: assert property (acc_valid && acc_write && acc_is_flash && !st_r.loaded && !blocked
        && !(st_r.key_acc && fsc_is_key_addr(acc_addr)) |=> acc_err_set && !cmd_start)
        else $error("early flash write not flagged");
endmodule // fsc_top
